// >>> hdl/accel_sample_fifo.sv
// Purpose: 32-entry three-axis sample buffer between measurement and output data.
// Assumes: Samples, interrupt pulses and control byte arrive on clk; the serial
//          link's read activity arrives on link_clk and chip select on a pin.
// Notes:   Output data shows live samples in bypass, popped samples otherwise.
//
// How it works
// - Thirty-two entries, four modes chosen by control bits 7:6.
// - Bypass stores nothing; buffer stays empty.
// - Stop-when-full pushes each sample; watermark raised when count reaches level.
// - Stop-when-full refuses samples once 32 stored; rest of device runs on.
// - Watermark holds while stored count is at or above level.
// - Stream keeps newest 32, dropping oldest when full; watermark at level.
// - Trigger mode, before trigger, keeps newest 32 circularly.
// - On trigger keep newest n (level), then behave as stop-when-full.
// - Trigger is the interrupt on the pin picked by trigger-select bit.
// - After one captured trigger, further triggers ignored until re-armed.
// - Entering bypass empties the buffer.
// - Outside bypass, data registers return buffered samples, not live ones.
// - Each pop moves the oldest sample into x, y and z outputs.
// - A single-byte read still pops; unread bytes of that sample are lost.
// - Read ends, and pop starts, on address step 0x37 to 0x38 or chip select high.
// - Watermark clears itself when reads bring count below level.
// - Outside bypass, overrun flag set when buffer becomes full.
// - Overrun flag clears when buffer contents are read.

`timescale 1ns/10ps

module accel_sample_fifo (
  // Core clock and reset
  input  wire logic                                   clk,
  input  wire logic                                   reset_n,
  // Serial link side
  input  wire logic                                   link_clk,
  input  wire logic                                   link_cs_n,
  input  wire logic                                   link_rd_strobe,
  input  wire logic [sample_buf_pkg::ADDR_W-1:0]      link_rd_addr,
  // Measurement path
  input  wire logic                                   sample_valid,
  input  wire logic [sample_buf_pkg::AXIS_W-1:0]      sample_x,
  input  wire logic [sample_buf_pkg::AXIS_W-1:0]      sample_y,
  input  wire logic [sample_buf_pkg::AXIS_W-1:0]      sample_z,
  // Interrupt pin events
  input  wire logic                                   interrupt_pin_one,
  input  wire logic                                   interrupt_pin_two,
  // Control
  input  wire logic [7:0]                             buffer_control_register,
  // Output data
  output      logic [sample_buf_pkg::AXIS_W-1:0]      x_axis_output,
  output      logic [sample_buf_pkg::AXIS_W-1:0]      y_axis_output,
  output      logic [sample_buf_pkg::AXIS_W-1:0]      z_axis_output,
  // Status
  output      logic [sample_buf_pkg::CNT_W-1:0]       entry_count,
  output      logic                                   watermark_flag,
  output      logic                                   overrun_flag,
  output      logic                                   trigger_captured
);

  // ************************************************************
  // Types and state
  // ************************************************************
  typedef struct packed {
    logic [sample_buf_pkg::DEPTH-1:0][sample_buf_pkg::SAMPLE_W-1:0] mem;
    logic [sample_buf_pkg::PTR_W-1:0]  wr_ptr;
    logic [sample_buf_pkg::PTR_W-1:0]  rd_ptr;
    logic [sample_buf_pkg::CNT_W-1:0]  count;
    logic                              trig_done;
    logic                              wm;
    logic                              ovr;
    logic                              pend;
    logic [2:0]                        prev;
    logic [sample_buf_pkg::AXIS_W-1:0] out_x;
    logic [sample_buf_pkg::AXIS_W-1:0] out_y;
    logic [sample_buf_pkg::AXIS_W-1:0] out_z;
  } core_state_t;

  core_state_t                            s_r;
  core_state_t                            s_nxt;
  link_pop_if                             pop_if ();
  logic [2:0]                             sync_lvl;
  sample_buf_pkg::buf_mode_t              mode;
  logic [sample_buf_pkg::LEVEL_W-1:0]     level;
  logic [sample_buf_pkg::CNT_W-1:0]       level_cnt;
  logic                                   trig_sel;
  logic                                   trig_evt;
  logic                                   data_edge;
  logic                                   inc_edge;
  logic                                   cs_rise;
  logic                                   pop_go;
  logic [sample_buf_pkg::SAMPLE_W-1:0]    new_sample;
  logic                                   wrap_ok;

  // ************************************************************
  // Link domain and crossing
  // ************************************************************

  // Read tracking runs on the link's own clock
  link_read_tracker u_tracker (
    .link_clk       (link_clk),
    .reset_n        (reset_n),
    .link_rd_strobe (link_rd_strobe),
    .link_rd_addr   (link_rd_addr),
    .pop_if         (pop_if.link)
  );

  // Chip select idles high, so its synchroniser resets high
  level_sync #(
    .WIDTH     (3),
    .RESET_VAL (3'h4)
  ) u_sync (
    .clk      (clk),
    .reset_n  (reset_n),
    .async_in ({link_cs_n, pop_if.data_tgl, pop_if.inc_tgl}),
    .sync_out (sync_lvl)
  );

  // Edges seen after synchronisation only
  assign data_edge = sync_lvl[1] ^ s_r.prev[1];
  assign inc_edge  = sync_lvl[0] ^ s_r.prev[0];
  assign cs_rise   = sync_lvl[2] & ~s_r.prev[2];

  // A read ends on the step past the last data byte or on chip select
  // release, but only pops if a data byte was read in that transfer
  assign pop_go = (inc_edge | cs_rise) & (s_r.pend | data_edge);

  // ************************************************************
  // Control decode
  // ************************************************************
  assign mode      = sample_buf_pkg::buf_mode_t'(
                       buffer_control_register[sample_buf_pkg::MODE_HI:
                                               sample_buf_pkg::MODE_LO]);
  assign trig_sel  = buffer_control_register[sample_buf_pkg::TRIG_BIT];
  assign level     = buffer_control_register[sample_buf_pkg::LEVEL_HI:
                                             sample_buf_pkg::LEVEL_LO];
  assign level_cnt = {1'b0, level};
  assign trig_evt  = trig_sel ? interrupt_pin_two : interrupt_pin_one;
  assign new_sample = {sample_z, sample_y, sample_x};

  // Overwriting the oldest entry is allowed in stream and in trigger mode
  // until a trigger has been captured
  assign wrap_ok = (mode == sample_buf_pkg::MODE_STREAM) ||
                   (mode == sample_buf_pkg::MODE_TRIGGER && !s_r.trig_done);

  // ************************************************************
  // Buffer next state
  // ************************************************************

  // Order within one cycle: trigger trim, then pop, then push, so a pop and a
  // push in the same cycle never lose a sample
  always_comb begin
    s_nxt      = s_r;
    s_nxt.prev = sync_lvl;
    s_nxt.pend = pop_go ? 1'b0 : (s_r.pend | data_edge);

    if (mode == sample_buf_pkg::MODE_BYPASS) begin
      // Bypass holds the buffer empty and re-arms trigger capture
      s_nxt.wr_ptr    = '0;
      s_nxt.rd_ptr    = '0;
      s_nxt.count     = '0;
      s_nxt.trig_done = 1'b0;
      s_nxt.ovr       = 1'b0;
      if (sample_valid) begin
        s_nxt.out_x = sample_x;
        s_nxt.out_y = sample_y;
        s_nxt.out_z = sample_z;
      end
    end else begin
      // First trigger trims to the newest n and freezes wrapping
      if (mode == sample_buf_pkg::MODE_TRIGGER && trig_evt && !s_r.trig_done) begin
        s_nxt.trig_done = 1'b1;
        if (s_r.count > level_cnt) begin
          s_nxt.count  = level_cnt;
          s_nxt.rd_ptr = s_r.wr_ptr - level;
        end
      end

      // Pop the oldest entry into the output data registers
      if (pop_go && s_nxt.count != '0) begin
        s_nxt.out_x  = s_r.mem[s_nxt.rd_ptr][sample_buf_pkg::AXIS_W-1:0];
        s_nxt.out_y  = s_r.mem[s_nxt.rd_ptr][2*sample_buf_pkg::AXIS_W-1:
                                              sample_buf_pkg::AXIS_W];
        s_nxt.out_z  = s_r.mem[s_nxt.rd_ptr][sample_buf_pkg::SAMPLE_W-1:
                                              2*sample_buf_pkg::AXIS_W];
        s_nxt.rd_ptr = s_nxt.rd_ptr + 5'h01;
        s_nxt.count  = s_nxt.count - 6'h01;
        s_nxt.ovr    = 1'b0;
      end

      // Push a new sample, refusing or wrapping when full
      if (sample_valid) begin
        if (s_nxt.count < sample_buf_pkg::FULL_COUNT) begin
          s_nxt.mem[s_nxt.wr_ptr] = new_sample;
          s_nxt.wr_ptr = s_nxt.wr_ptr + 5'h01;
          s_nxt.count  = s_nxt.count + 6'h01;
        end else if (wrap_ok) begin
          // Oldest entry dropped to admit the newest
          s_nxt.mem[s_nxt.wr_ptr] = new_sample;
          s_nxt.wr_ptr = s_nxt.wr_ptr + 5'h01;
          s_nxt.rd_ptr = s_nxt.rd_ptr + 5'h01;
        end
        // Otherwise stop-when-full: the sample is simply not stored
      end

      // Full sets overrun; evaluated after the pop so the set wins
      if (s_nxt.count == sample_buf_pkg::FULL_COUNT) begin
        s_nxt.ovr = 1'b1;
      end
    end

    // Watermark follows the count both ways, so reads clear it
    s_nxt.wm = (mode != sample_buf_pkg::MODE_BYPASS) &&
               (s_nxt.count >= level_cnt);
  end

  // ************************************************************
  // State register
  // ************************************************************

  // Reset clears the state, memory included, and loads prev with chip select high, so no read ever sees X
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      s_r      <= '0;
      s_r.prev <= 3'h4;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ************************************************************
  // Outputs, all from the state register
  // ************************************************************
  assign x_axis_output    = s_r.out_x;
  assign y_axis_output    = s_r.out_y;
  assign z_axis_output    = s_r.out_z;
  assign entry_count      = s_r.count;
  assign watermark_flag   = s_r.wm;
  assign overrun_flag     = s_r.ovr;
  assign trigger_captured = s_r.trig_done;

endmodule

// >>> hdl/sample_buf_pkg.sv
// Purpose: Shared constants and encodings for the sample buffer block.
// Assumes: One sample is three 16-bit axis values.
// Notes:   The host pop delay is kept here for the verification side.

package sample_buf_pkg;

  // ************************************************************
  // Buffer geometry
  // ************************************************************
  localparam int DEPTH    = 32;
  localparam int PTR_W    = 5;
  localparam int CNT_W    = 6;
  localparam int AXIS_W   = 16;
  localparam int SAMPLE_W = 3 * AXIS_W;
  localparam logic [CNT_W-1:0] FULL_COUNT = 6'h20;

  // ************************************************************
  // Control byte layout
  // ************************************************************
  localparam int MODE_HI  = 7;
  localparam int MODE_LO  = 6;
  localparam int TRIG_BIT = 5;
  localparam int LEVEL_HI = 4;
  localparam int LEVEL_LO = 0;
  localparam int LEVEL_W  = LEVEL_HI - LEVEL_LO + 1;

  // Mode field encoding
  typedef enum logic [1:0] {
    MODE_BYPASS  = 2'h0,
    MODE_STOP    = 2'h1,
    MODE_STREAM  = 2'h2,
    MODE_TRIGGER = 2'h3
  } buf_mode_t;

  // ************************************************************
  // Register addresses seen on the serial link
  // ************************************************************
  localparam int ADDR_W = 8;
  localparam logic [ADDR_W-1:0] ADDR_DATA_FIRST = 8'h32;
  localparam logic [ADDR_W-1:0] ADDR_DATA_LAST  = 8'h37;
  localparam logic [ADDR_W-1:0] ADDR_CONTROL    = 8'h38;
  localparam logic [ADDR_W-1:0] ADDR_STATUS     = 8'h39;

  // ************************************************************
  // Timing
  // ************************************************************
  localparam int CLK_PERIOD_NS  = 100;
  localparam int POP_DELAY_NS   = 5000;
  localparam int POP_DELAY_CYC  = (POP_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

endpackage

// >>> hdl/link_pop_if.sv
// Purpose: Carries read-tracking toggles from the link domain to the core.
// Assumes: Both signals are toggles on link_clk, synchronised by the receiver.
// Notes:   No clock here; the core synchronises before use.

`timescale 1ns/10ps

interface link_pop_if;
  logic data_tgl;   // Flips on each data register byte read
  logic inc_tgl;    // Flips when the address steps past the last data byte

  modport link (output data_tgl, output inc_tgl);
  modport core (input data_tgl, input inc_tgl);
endinterface

// >>> hdl/level_sync.sv
// Purpose: Two-flop synchroniser for a group of independent levels.
// Assumes: Each bit changes slowly against clk (toggles or pin levels).
// Notes:   First stage feeds only the second stage.

`timescale 1ns/10ps

module level_sync #(
  parameter int               WIDTH     = 1,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             reset_n,
  // Levels
  input  wire logic [WIDTH-1:0] async_in,
  output      logic [WIDTH-1:0] sync_out
);

  typedef struct packed {
    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] stage2;
  } sync_state_t;

  sync_state_t s_r;
  sync_state_t s_nxt;

  // Shift one stage per edge
  always_comb begin
    s_nxt        = s_r;
    s_nxt.stage1 = async_in;
    s_nxt.stage2 = s_r.stage1;
  end

  // State register
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      s_r <= {RESET_VAL, RESET_VAL};
    end else begin
      s_r <= s_nxt;
    end
  end

  assign sync_out = s_r.stage2;

endmodule

// >>> hdl/link_read_tracker.sv
// Purpose: Watches register reads on the link clock and flags data reads.
// Assumes: rd_strobe is one link_clk cycle per byte read, address valid with it.
// Notes:   Only toggles leave this domain; the core decides when to pop.

`timescale 1ns/10ps

module link_read_tracker (
  // Link clock and reset
  input  wire logic                               link_clk,
  input  wire logic                               reset_n,
  // Byte reads on the link
  input  wire logic                               link_rd_strobe,
  input  wire logic [sample_buf_pkg::ADDR_W-1:0]  link_rd_addr,
  // Toward the core
  link_pop_if.link                                pop_if
);

  typedef struct packed {
    logic data_tgl;
    logic inc_tgl;
    logic last_hi;
  } track_state_t;

  track_state_t s_r;
  track_state_t s_nxt;
  logic         is_data;

  assign is_data = (link_rd_addr >= sample_buf_pkg::ADDR_DATA_FIRST) &&
                   (link_rd_addr <= sample_buf_pkg::ADDR_DATA_LAST);

  // Byte reads of data registers and the step from last data byte onward
  always_comb begin
    s_nxt = s_r;
    if (link_rd_strobe) begin
      if (is_data) begin
        s_nxt.data_tgl = ~s_r.data_tgl;
      end
      if (s_r.last_hi && link_rd_addr == sample_buf_pkg::ADDR_CONTROL) begin
        s_nxt.inc_tgl = ~s_r.inc_tgl;
      end
      s_nxt.last_hi = (link_rd_addr == sample_buf_pkg::ADDR_DATA_LAST);
    end
  end

  // A stale last_hi across frames is harmless: the core only pops when a data
  // read is pending
  always_ff @(posedge link_clk or negedge reset_n) begin
    if (!reset_n) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign pop_if.data_tgl = s_r.data_tgl;
  assign pop_if.inc_tgl  = s_r.inc_tgl;

endmodule

// >>> dv/accel_sample_fifo_sva.sv
// Purpose: Port-level checks on the sample buffer.
// Assumes: Link frames are only used for data reads.
// Notes:   "quiet" means chip select high long enough that no pop is in flight.
`timescale 1ns/10ps
module accel_sample_fifo_sva (
  // Clock and reset
  input wire logic                              clk,
  input wire logic                              reset_n,
  // Inputs watched
  input wire logic                              link_cs_n,
  input wire logic                              link_rd_strobe,
  input wire logic [sample_buf_pkg::ADDR_W-1:0] link_rd_addr,
  input wire logic                              sample_valid,
  input wire logic                              interrupt_pin_one,
  input wire logic                              interrupt_pin_two,
  input wire logic [7:0]                        buffer_control_register,
  // Outputs watched
  input wire logic [sample_buf_pkg::AXIS_W-1:0] x_axis_output,
  input wire logic [sample_buf_pkg::AXIS_W-1:0] y_axis_output,
  input wire logic [sample_buf_pkg::AXIS_W-1:0] z_axis_output,
  input wire logic [sample_buf_pkg::CNT_W-1:0]  entry_count,
  input wire logic                              watermark_flag,
  input wire logic                              overrun_flag,
  input wire logic                              trigger_captured
);
  logic [3:0] cs_hi_r;
  logic       rd_seen_r;
  logic [1:0] mode;
  logic [4:0] lvl;
  logic       quiet;
  logic       pin_sel;
  assign mode    = buffer_control_register[7:6];
  assign lvl     = buffer_control_register[4:0];
  assign quiet   = cs_hi_r == 4'hf;
  assign pin_sel = buffer_control_register[5] ? interrupt_pin_two : interrupt_pin_one;
  // Chip select high time and a data read not yet closed by the 0x38 step
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cs_hi_r   <= 4'h0;
      rd_seen_r <= 1'b0;
    end else begin
      cs_hi_r   <= link_cs_n ? (quiet ? cs_hi_r : cs_hi_r + 4'h1) : 4'h0;
      if (link_cs_n || (link_rd_strobe && link_rd_addr == 8'h38)) begin
        rd_seen_r <= 1'b0;
      end else if (link_rd_strobe && link_rd_addr inside {[8'h32:8'h37]}) begin
        rd_seen_r <= 1'b1;
      end
    end
  end

  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  // Two steady cycles, so flags and count describe the same state
  sequence settled;
    (quiet && !sample_valid && !interrupt_pin_one && !interrupt_pin_two
     && $stable(buffer_control_register)) [*2];
  endsequence
  sequence trig_evt;
    mode == 2'h3 && !trigger_captured && quiet && !sample_valid && pin_sel;
  endsequence

  a_bypass_empty:  assert property (mode == 2'h0 |=> entry_count == 6'h00)
    else $error("buffer not empty in bypass");
  a_count_bound:   assert property (entry_count <= 6'h20)
    else $error("entry count above depth");
  a_stop_push:     assert property (quiet && mode == 2'h1 && sample_valid && entry_count < 6'h20
    |=> entry_count == $past(entry_count) + 6'h01) else $error("sample not stored");
  a_stop_full:     assert property (quiet && mode == 2'h1 && entry_count == 6'h20
    |=> entry_count == 6'h20) else $error("full buffer changed count");
  a_stream_keep:   assert property (quiet && entry_count == 6'h20 && !pin_sel
    && (mode == 2'h2 || (mode == 2'h3 && !trigger_captured)) |=> entry_count == 6'h20)
    else $error("circular buffer lost depth");
  a_watermark_lvl: assert property (settled |-> watermark_flag
    == (mode != 2'h0 && entry_count >= {1'b0, lvl})) else $error("watermark wrong");
  a_overrun_full:  assert property (settled ##0 mode inside {2'h1, 2'h2}
    |-> overrun_flag == (entry_count == 6'h20)) else $error("overrun wrong");
  a_trigger_trim:  assert property (trig_evt |=> trigger_captured && entry_count
    == ($past(entry_count) > {1'b0, $past(lvl)} ? {1'b0, $past(lvl)} : $past(entry_count)))
    else $error("trigger trim wrong");
  a_trigger_once:  assert property (mode == 2'h3 && trigger_captured && quiet && !sample_valid
    |=> trigger_captured && entry_count == $past(entry_count)) else $error("second trigger");
  a_outputs_hold:  assert property (quiet && mode != 2'h0
    |=> $stable({x_axis_output, y_axis_output, z_axis_output})) else $error("outputs live");
  a_pop_on_cs:     assert property ($rose(link_cs_n) && rd_seen_r && mode == 2'h1
    && entry_count == 6'h20 |-> ##[1:10] (entry_count < 6'h20 || $past(sample_valid)))
    else $error("no pop at chip select");
endmodule

// >>> dv/host_reader.sv
// Purpose: Host model reading the output data over the serial link.
// Assumes: Link clock 125 ns, running only inside frames.
// Notes:   Address line is inverted outside strobes so it never looks held.
`timescale 1ns/10ps
module host_reader (
  // Link toward the block
  output logic       link_clk,
  output logic       link_cs_n,
  output logic       link_rd_strobe,
  output logic [7:0] link_rd_addr
);
  // Idle link: clock parked low, chip select released
  initial begin
    link_clk       = 1'b0;
    link_cs_n      = 1'b1;
    link_rd_strobe = 1'b0;
    link_rd_addr   = 8'h00;
  end
  // One link period
  task automatic tick();
    #62.5 link_clk = 1'b1;
    #62.5 link_clk = 1'b0;
  endtask
  // Burst read; ends by the step past 0x37 or by chip select going high
  task automatic read_frame(input logic [7:0] first, input int nbytes);
    #37 link_cs_n = 1'b0;
    repeat (8) tick();
    for (int i = 0; i < nbytes; i++) begin
      link_rd_strobe = 1'b1;
      link_rd_addr   = first + 8'(i);
      tick();
      link_rd_strobe = 1'b0;
      link_rd_addr   = ~link_rd_addr;
      repeat (7) tick();
    end
    link_cs_n    = 1'b1;
    link_rd_addr = ~link_rd_addr;
    #(sample_buf_pkg::POP_DELAY_NS);
  endtask
endmodule

// >>> dv/tb_top.sv
// Purpose: Self-checking bench for the sample buffer.
// Assumes: Inputs change 10 ns after the rising clock edge.
// Notes:   A queue model tracks what the buffer should hold.
`timescale 1ns/10ps
module tb_top;
  logic        clk, reset_n, sample_valid, link_clk, link_cs_n, link_rd_strobe;
  logic        interrupt_pin_one, interrupt_pin_two, captured;
  logic        watermark_flag, overrun_flag, trigger_captured;
  logic [15:0] sample_x, sample_y, sample_z, x_axis_output, y_axis_output, z_axis_output;
  logic [15:0] lfsr_r;
  logic [7:0]  buffer_control_register, link_rd_addr;
  logic [5:0]  entry_count;
  logic [4:0]  lvl;
  logic [47:0] live;
  logic [47:0] q[$];
  int          failures, cmp_count, cycles;

  accel_sample_fifo u_accel_sample_fifo (.clk, .reset_n, .link_clk, .link_cs_n,
    .link_rd_strobe, .link_rd_addr, .sample_valid, .sample_x, .sample_y, .sample_z,
    .interrupt_pin_one, .interrupt_pin_two, .buffer_control_register, .x_axis_output,
    .y_axis_output, .z_axis_output, .entry_count, .watermark_flag, .overrun_flag,
    .trigger_captured);
  host_reader u_host_reader (.link_clk, .link_cs_n, .link_rd_strobe, .link_rd_addr);

  always #50 clk = ~clk;
  // Hang guard
  always @(posedge clk) begin
    cycles++;
    if (cycles == 30000) begin
      failures++;
      complete_run();
    end
  end

  function automatic logic [15:0] rnd();
    lfsr_r = {lfsr_r[14:0], lfsr_r[15] ^ lfsr_r[13] ^ lfsr_r[12] ^ lfsr_r[10]};
    return lfsr_r;
  endfunction
  // Model of one incoming sample
  function automatic void model_push(input logic [47:0] s);
    logic [1:0] m;
    m = buffer_control_register[7:6];
    if (m == 2'h0) live = s;
    else if (m == 2'h2 || (m == 2'h3 && !captured) || q.size() < 32) q.push_back(s);
    if (q.size() > 32) void'(q.pop_front());
  endfunction
  task automatic check(input string what, input logic [47:0] seen, input logic [47:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic check_state();
    check("axes", {x_axis_output, y_axis_output, z_axis_output}, live);
    check("count", 48'(entry_count), 48'(q.size()));
    check("watermark", 48'(watermark_flag),
          48'(buffer_control_register[7:6] != 2'h0 && q.size() >= lvl));
  endtask
  task automatic set_ctl(input logic [1:0] m, input logic t, input logic [4:0] n);
    @(posedge clk);
    #10 buffer_control_register = {m, t, n};
    lvl = n;
    if (m == 2'h0) begin
      q.delete();
      captured = 1'b0;
    end
    repeat (3) @(posedge clk);
  endtask
  task automatic push(input int k);
    repeat (k) begin
      @(posedge clk);
      #10 sample_x = rnd();
      sample_y     = rnd();
      sample_z     = rnd();
      sample_valid = 1'b1;
      model_push({sample_x, sample_y, sample_z});
    end
    @(posedge clk);
    #10 sample_valid = 1'b0;
    repeat (3) @(posedge clk);
  endtask
  task automatic pop(input logic [7:0] first, input int nbytes);
    u_host_reader.read_frame(first, nbytes);
    if (buffer_control_register[7:6] != 2'h0 && q.size() > 0) live = q.pop_front();
    check_state();
  endtask
  task automatic pulse(input logic two);
    @(posedge clk);
    #10 interrupt_pin_one = !two;
    interrupt_pin_two = two;
    if (buffer_control_register[7:5] == {2'h3, two} && !captured) begin
      captured = 1'b1;
      while (q.size() > lvl) void'(q.pop_front());
    end
    @(posedge clk);
    #10 interrupt_pin_one = 1'b0;
    interrupt_pin_two = 1'b0;
    repeat (3) @(posedge clk);
    repeat (sample_buf_pkg::POP_DELAY_CYC) @(posedge clk);
  endtask
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  // Main sequence
  initial begin
    {clk, reset_n, sample_valid, interrupt_pin_one, interrupt_pin_two, captured} = '0;
    {sample_x, sample_y, sample_z, buffer_control_register, live, lvl} = '0;
    lfsr_r = 16'h0711;
    repeat (10) @(posedge clk);
    #10 reset_n = 1'b1;
    push(4);
    check_state();
    $display("test bypass done");
    set_ctl(2'h1, 1'b0, 5'(rnd() % 8 + 24));
    push(34);
    check_state();
    check("overrun", 48'(overrun_flag), 48'h1);
    pop(8'h34, 1);
    check("overrun", 48'(overrun_flag), 48'h0);
    while (q.size() >= lvl) pop(8'h32, 7);
    $display("test stop done");
    set_ctl(2'h0, 1'b0, 5'h00);
    check_state();
    set_ctl(2'h2, 1'b0, 5'h10);
    push(40);
    pop(8'h32, 7);
    $display("test stream done");
    set_ctl(2'h0, 1'b0, 5'h00);
    set_ctl(2'h3, 1'b1, 5'h05);
    push(40);
    check_state();
    pulse(1'b0);
    check("captured", 48'(trigger_captured), 48'h0);
    pulse(1'b1);
    check("captured", 48'(trigger_captured), 48'h1);
    push(3);
    pulse(1'b1);
    check_state();
    push(30);
    pop(8'h32, 7);
    set_ctl(2'h0, 1'b0, 5'h00);
    set_ctl(2'h3, 1'b1, 5'h05);
    check("captured", 48'(trigger_captured), 48'h0);
    $display("test trigger done");
    complete_run();
  end
endmodule

bind accel_sample_fifo accel_sample_fifo_sva u_accel_sample_fifo_sva (.clk, .reset_n,
  .link_cs_n, .link_rd_strobe, .link_rd_addr, .sample_valid, .interrupt_pin_one,
  .interrupt_pin_two, .buffer_control_register, .x_axis_output, .y_axis_output,
  .z_axis_output, .entry_count, .watermark_flag, .overrun_flag, .trigger_captured);
